// *** hdl/dpc_defines.vh ***
// constants for the dual wiper serial command decoder
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH
// frame layout
`define DPC_FRAME_BITS    24
`define DPC_OPC_MSB       23
`define DPC_OPC_LSB       20
`define DPC_ADDR_MSB      19
`define DPC_ADDR_LSB      16
`define DPC_WORD_MSB      15
`define DPC_WIPER_MSB     9
`define DPC_WIPER_BITS    10
`define DPC_WORD_BITS     16
`define DPC_NUM_WORDS     16
// opcodes
`define DPC_OP_NOP        4'h0
`define DPC_OP_RESTORE    4'h1
`define DPC_OP_STORE      4'h2
`define DPC_OP_WR_WORD    4'h3
`define DPC_OP_SHR_ONE    4'h4
`define DPC_OP_SHR_ALL    4'h5
`define DPC_OP_DEC_ONE    4'h6
`define DPC_OP_DEC_ALL    4'h7
`define DPC_OP_RELOAD     4'h8
`define DPC_OP_RD_WORD    4'h9
`define DPC_OP_RD_WIPER   4'ha
`define DPC_OP_WR_WIPER   4'hb
`define DPC_OP_SHL_ONE    4'hc
`define DPC_OP_SHL_ALL    4'hd
`define DPC_OP_INC_ONE    4'he
`define DPC_OP_INC_ALL    4'hf
// reset values and full-scale wiper value
`define DPC_WORD_RESET    16'h0200
`define DPC_WIPER_FULL    10'h3ff
`define DPC_WIPER_MID     10'h200
`endif

// *** hdl/dpc_sync.v ***
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module dpc_sync
#(
  parameter RESET_VAL = 1'b0
)
(
  // clock and reset
  input  wire core_clk,
  input  wire reset_n,
  // level in and out
  input  wire async_in,
  output reg  sync_out
);

  reg meta_reg;

  // first stage feeds only the second
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// *** hdl/dpc_wiper_alu.v ***
// next wiper value for the step and shift opcodes
`timescale 1ns/10ps
`include "dpc_defines.vh"
module dpc_wiper_alu
#(
  parameter W = `DPC_WIPER_BITS
)
(
  // operation and value
  input  wire [3:0]   opcode,
  input  wire [W-1:0] wiper_in,
  // result
  output reg  [W-1:0] wiper_out
);

  // one step per opcode, all saturating
  always @*
  begin
    wiper_out = wiper_in;
    case (opcode)
      `DPC_OP_SHR_ONE, `DPC_OP_SHR_ALL:
        wiper_out = wiper_in >> 1;
      `DPC_OP_DEC_ONE, `DPC_OP_DEC_ALL:
        if (wiper_in != {W{1'b0}})
          wiper_out = wiper_in - {{(W-1){1'b0}}, 1'b1};
      `DPC_OP_SHL_ONE, `DPC_OP_SHL_ALL:
      begin
        if (wiper_in == {W{1'b0}})
          wiper_out = {{(W-1){1'b0}}, 1'b1};
        else if (wiper_in[W-1])
          wiper_out = {W{1'b1}};
        else
          wiper_out = {wiper_in[W-2:0], 1'b0};
      end
      `DPC_OP_INC_ONE, `DPC_OP_INC_ALL:
        if (wiper_in != {W{1'b1}})
          wiper_out = wiper_in + {{(W-1){1'b0}}, 1'b1};
      default:
        wiper_out = wiper_in;
    endcase
  end

endmodule

// *** hdl/dpc_decoder.v ***
// serial command decoder for a dual channel digital potentiometer
`timescale 1ns/10ps
`include "dpc_defines.vh"
module dpc_decoder
#(
  parameter FRAME_BITS = `DPC_FRAME_BITS,
  parameter WIPER_BITS = `DPC_WIPER_BITS,
  parameter WORD_BITS  = `DPC_WORD_BITS,
  parameter NUM_WORDS  = `DPC_NUM_WORDS
)
(
  // clock and reset
  input  wire                  core_clk,
  input  wire                  reset_n,
  // serial link pins
  input  wire                  spi_cs_n,
  input  wire                  spi_sclk,
  input  wire                  spi_mosi,
  output reg                   spi_miso_out,
  output reg                   spi_miso_oe_n,
  // clock mode strap: 1 selects idle high, phase 1
  input  wire                  clk_idle_high,
  // wiper positions
  output reg  [WIPER_BITS-1:0] wiper0_reg,
  output reg  [WIPER_BITS-1:0] wiper1_reg,
  // read power state and busy
  output reg                   read_state_reg,
  output reg                   exec_pulse_reg
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  wire cs_n_s;
  wire sclk_s;
  wire mosi_s;
  wire mode_s;

  dpc_sync #(.RESET_VAL(1'b1)) u_sync_cs
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (spi_cs_n),
    .sync_out (cs_n_s)
  );

  dpc_sync #(.RESET_VAL(1'b0)) u_sync_sclk
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (spi_sclk),
    .sync_out (sclk_s)
  );

  dpc_sync #(.RESET_VAL(1'b0)) u_sync_mosi
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (spi_mosi),
    .sync_out (mosi_s)
  );

  dpc_sync #(.RESET_VAL(1'b0)) u_sync_mode
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (clk_idle_high),
    .sync_out (mode_s)
  );

  // ****************************************************************
  // edge detection
  // ****************************************************************
  reg  cs_n_d_reg;
  reg  sclk_d_reg;
  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire sclk_fall;
  wire sample_edge;
  wire shift_edge;

  // delayed copies of synchronised levels
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      cs_n_d_reg <= cs_n_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign cs_fall   = cs_n_d_reg & ~cs_n_s;
  assign cs_rise   = ~cs_n_d_reg & cs_n_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s;
  // both modes sample on rising and launch on falling edge
  assign sample_edge = ~cs_n_s & sclk_rise;
  assign shift_edge  = ~cs_n_s & sclk_fall;

  // ****************************************************************
  // shift register and bit counter
  // ****************************************************************
  reg  [FRAME_BITS-1:0] shift_reg;
  reg  [FRAME_BITS-1:0] out_reg;
  reg  [5:0]            bit_cnt_reg;
  reg                   clk_seen_reg;
  reg                   out_bit_reg;
  reg                   phase_reg;
  wire [FRAME_BITS-1:0] out_load;

  // mode latched at each select fall
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_reg <= 1'b0;
    else if (cs_fall)
      phase_reg <= mode_s;
  end

  // shift in msb first on sample edges
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg    <= {FRAME_BITS{1'b0}};
      bit_cnt_reg  <= 6'h00;
      clk_seen_reg <= 1'b0;
    end
    else if (cs_fall)
    begin
      clk_seen_reg <= 1'b0;
    end
    else if (sample_edge)
    begin
      shift_reg    <= {shift_reg[FRAME_BITS-2:0], mosi_s};
      clk_seen_reg <= 1'b1;
      if (bit_cnt_reg == 6'h2f)
        bit_cnt_reg <= 6'h18;
      else
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
    else if (cs_rise & ((bit_cnt_reg[1:0] != 2'h0) | clk_seen_reg))
      bit_cnt_reg <= 6'h00; // garbled or finished frame
  end

  // ****************************************************************
  // serial output
  // ****************************************************************
  // outgoing frame: echo or readback word
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_reg     <= {FRAME_BITS{1'b0}};
      out_bit_reg <= 1'b0;
    end
    else if (cs_fall)
    begin
      out_reg     <= out_load;
      out_bit_reg <= out_load[FRAME_BITS-1];
    end
    else if (shift_edge & (~phase_reg | clk_seen_reg))
    begin
      out_reg     <= {out_reg[FRAME_BITS-2:0], shift_reg[0]};
      out_bit_reg <= out_reg[FRAME_BITS-2];
    end
  end

  // open-drain: enable low pulls the line to the bit level
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      spi_miso_out  <= 1'b1;
      spi_miso_oe_n <= 1'b1;
    end
    else
    begin
      spi_miso_out  <= 1'b0;
      spi_miso_oe_n <= cs_n_s | out_bit_reg; // low only when driving zero
    end
  end

  // ****************************************************************
  // stored words
  // ****************************************************************
  reg [WORD_BITS-1:0] word_mem [0:NUM_WORDS-1];
  reg [WORD_BITS-1:0] read_word_reg;
  reg                 read_pend_reg;
  integer             i;

  // ****************************************************************
  // command decode
  // ****************************************************************
  reg  [FRAME_BITS-1:0] cmd_reg;
  reg                   cmd_valid_reg;
  reg                   boot_reg;
  wire [FRAME_BITS-1:0] cmd_now;
  wire [3:0]            opcode;
  wire [3:0]            addr;
  wire                  chan;
  wire [WORD_BITS-1:0]  data_word;
  wire [WIPER_BITS-1:0] data_wiper;
  wire                  do_exec;
  wire [WIPER_BITS-1:0] alu0_out;
  wire [WIPER_BITS-1:0] alu1_out;
  wire [WIPER_BITS-1:0] sel_wiper;

  // clocked frame or repeat of the previous one
  assign cmd_now    = clk_seen_reg ? shift_reg : cmd_reg;
  assign opcode     = cmd_now[`DPC_OPC_MSB:`DPC_OPC_LSB];
  assign addr       = cmd_now[`DPC_ADDR_MSB:`DPC_ADDR_LSB];
  assign chan       = addr[0];
  assign data_word  = cmd_now[`DPC_WORD_MSB:0];
  assign data_wiper = cmd_now[`DPC_WIPER_MSB:0];
  assign sel_wiper  = chan ? wiper1_reg : wiper0_reg;
  // frames of 24 or more bits whose count is a multiple of four execute
  assign do_exec = cs_rise & (bit_cnt_reg[1:0] == 2'h0) &
                   (clk_seen_reg ? (bit_cnt_reg >= 6'h18) :
                    cmd_valid_reg);
  // readback goes into the data bytes of the next frame
  assign out_load = read_pend_reg ?
                    {shift_reg[FRAME_BITS-1:WORD_BITS], read_word_reg} :
                    shift_reg;

  dpc_wiper_alu #(.W(WIPER_BITS)) u_alu0
  (
    .opcode    (opcode),
    .wiper_in  (wiper0_reg),
    .wiper_out (alu0_out)
  );

  dpc_wiper_alu #(.W(WIPER_BITS)) u_alu1
  (
    .opcode    (opcode),
    .wiper_in  (wiper1_reg),
    .wiper_out (alu1_out)
  );

  // execution at select rise
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wiper0_reg     <= `DPC_WIPER_MID;
      wiper1_reg     <= `DPC_WIPER_MID;
      read_state_reg <= 1'b0;
      exec_pulse_reg <= 1'b0;
      read_pend_reg  <= 1'b0;
      read_word_reg  <= {WORD_BITS{1'b0}};
      cmd_reg        <= {FRAME_BITS{1'b0}};
      cmd_valid_reg  <= 1'b0;
      boot_reg       <= 1'b1;
      for (i = 0; i < NUM_WORDS; i = i + 1)
        word_mem[i] <= `DPC_WORD_RESET;
    end
    else if (boot_reg)
    begin
      // power-up refresh from stored words
      boot_reg   <= 1'b0;
      wiper0_reg <= word_mem[0][WIPER_BITS-1:0];
      wiper1_reg <= word_mem[1][WIPER_BITS-1:0];
    end
    else
    begin
      exec_pulse_reg <= do_exec;
      if (do_exec)
      begin
        cmd_reg       <= cmd_now;
        cmd_valid_reg <= 1'b1;
        read_pend_reg <= 1'b0;
        case (opcode)
          `DPC_OP_NOP:
            read_state_reg <= 1'b0;
          `DPC_OP_RESTORE:
          begin
            read_state_reg <= 1'b1;
            if (chan)
              wiper1_reg <= word_mem[1][WIPER_BITS-1:0];
            else
              wiper0_reg <= word_mem[0][WIPER_BITS-1:0];
          end
          `DPC_OP_STORE:
            word_mem[{3'h0, chan}] <=
              {{(WORD_BITS-WIPER_BITS){1'b0}}, sel_wiper};
          `DPC_OP_WR_WORD:
          begin
            word_mem[addr] <= data_word;
            if (addr == 4'h0)
              wiper0_reg <= data_word[WIPER_BITS-1:0];
            else if (addr == 4'h1)
              wiper1_reg <= data_word[WIPER_BITS-1:0];
          end
          `DPC_OP_RELOAD:
          begin
            wiper0_reg <= word_mem[0][WIPER_BITS-1:0];
            wiper1_reg <= word_mem[1][WIPER_BITS-1:0];
          end
          `DPC_OP_RD_WORD:
          begin
            read_word_reg <= word_mem[addr];
            read_pend_reg <= 1'b1;
          end
          `DPC_OP_RD_WIPER:
          begin
            read_word_reg <=
              {{(WORD_BITS-WIPER_BITS){1'b0}}, sel_wiper};
            read_pend_reg <= 1'b1;
          end
          `DPC_OP_WR_WIPER:
            if (chan)
              wiper1_reg <= data_wiper;
            else
              wiper0_reg <= data_wiper;
          `DPC_OP_SHR_ONE, `DPC_OP_DEC_ONE,
          `DPC_OP_SHL_ONE, `DPC_OP_INC_ONE:
            if (chan)
              wiper1_reg <= alu1_out;
            else
              wiper0_reg <= alu0_out;
          `DPC_OP_SHR_ALL, `DPC_OP_DEC_ALL,
          `DPC_OP_SHL_ALL, `DPC_OP_INC_ALL:
          begin
            wiper0_reg <= alu0_out;
            wiper1_reg <= alu1_out;
          end
          default:
            read_state_reg <= read_state_reg;
        endcase
      end
    end
  end

endmodule

// *** verif/dpc_decoder_monitor.sv ***
// port assertions for the serial command decoder
`timescale 1ns/10ps
`include "dpc_defines.vh"
module dpc_decoder_monitor
#(
  parameter WIPER_BITS = 10
)
(
  // clock and reset
  input wire                  core_clk,
  input wire                  reset_n,
  // link pins
  input wire                  spi_cs_n,
  input wire                  spi_miso_out,
  input wire                  spi_miso_oe_n,
  // state outputs
  input wire [WIPER_BITS-1:0] wiper0_reg,
  input wire [WIPER_BITS-1:0] wiper1_reg,
  input wire                  read_state_reg,
  input wire                  exec_pulse_reg
);
  logic       cs_q_reg;
  logic [3:0] since_reg;
  // cycles since chip select rose, saturating
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      cs_q_reg  <= 1'b1;
      since_reg <= 4'hf;
    end
    else
    begin
      cs_q_reg  <= spi_cs_n;
      since_reg <= (spi_cs_n && !cs_q_reg) ? 4'h0 :
                   (since_reg == 4'hf) ? since_reg : since_reg + 4'h1;
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_W0_QUIET: assert property (
    $changed(wiper0_reg) |-> spi_cs_n && since_reg <= 4'hb)
    else $error("wiper0 moved away from a frame end");
  AST_W1_QUIET: assert property (
    $changed(wiper1_reg) |-> spi_cs_n && since_reg <= 4'hb)
    else $error("wiper1 moved away from a frame end");
  AST_EXEC_ONE: assert property (
    exec_pulse_reg |=> !exec_pulse_reg)
    else $error("exec pulse longer than one cycle");
  AST_EXEC_AFTER_CS: assert property (
    exec_pulse_reg |-> spi_cs_n && since_reg <= 4'hb)
    else $error("exec pulse not after a select rise");
  AST_NO_EXEC_LOW: assert property (
    !spi_cs_n [*8] |-> !exec_pulse_reg)
    else $error("exec pulse while select low");
  AST_OE_IDLE: assert property (
    spi_cs_n [*5] |-> spi_miso_oe_n)
    else $error("data out driven while deselected");
  AST_OD_LOW: assert property (
    !spi_miso_oe_n |-> !spi_miso_out)
    else $error("open drain output drives high");
  AST_RS_QUIET: assert property (
    $changed(read_state_reg) |-> spi_cs_n && since_reg <= 4'hb)
    else $error("read state moved away from a frame end");
  AST_RESET_MID: assert property (
    !$past(reset_n) |-> wiper0_reg == `DPC_WIPER_MID &&
      wiper1_reg == `DPC_WIPER_MID)
    else $error("wipers not at stored value after reset");
endmodule
bind dpc_decoder dpc_decoder_monitor #(.WIPER_BITS(WIPER_BITS)) i_mon (
  .core_clk(core_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n),
  .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n),
  .wiper0_reg(wiper0_reg), .wiper1_reg(wiper1_reg),
  .read_state_reg(read_state_reg), .exec_pulse_reg(exec_pulse_reg));

// *** verif/dpc_host.sv ***
// serial host model driving the decoder link
`timescale 1ns/10ps
module dpc_host
(
  // clock reference
  input  wire  clk,
  // link pins
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  output logic mode,
  input  wire  miso_out,
  input  wire  miso_oe_n
);
  wire line;
  // open drain line with pull-up
  assign line = miso_oe_n ? 1'b1 : miso_out;
  // idle pins
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    mode = 1'b0;
  end
  // one frame of n bits, msb first, capturing the line
  task xfer(input int n, input logic [47:0] d, output logic [47:0] q);
    q = 48'h0;
    @(negedge clk);
    #1 cs_n = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = d[i];
      #62.5 sclk = 1'b1;
      q = {q[46:0], line};
      #62.5;
    end
    sclk = mode;
    #62.5 cs_n = 1'b1;
    mosi = ~mosi;
  endtask
  // select strobe with no clocks
  task pulse;
    @(negedge clk);
    #1 cs_n = 1'b0;
    #200 cs_n = 1'b1;
  endtask
  // clock idle level and phase
  task set_mode(input logic m);
    mode = m;
    sclk = m;
  endtask
endmodule

// *** verif/dpc_decoder_tb.sv ***
// testbench for the serial command decoder
`timescale 1ns/10ps
module dpc_decoder_tb;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  wire         cs_n, sclk, mosi, mode, miso_out, miso_oe_n;
  wire  [9:0]  wiper0, wiper1;
  wire         read_state, exec_pulse;
  int          fails = 0;
  int          num_checks = 0;
  logic [9:0]  ew [2];
  logic [15:0] em [16];
  logic [47:0] q;
  logic        ex;
  dpc_decoder i_dpc_decoder (.core_clk(core_clk), .reset_n(reset_n),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_miso_out(miso_out), .spi_miso_oe_n(miso_oe_n),
    .clk_idle_high(mode), .wiper0_reg(wiper0), .wiper1_reg(wiper1),
    .read_state_reg(read_state), .exec_pulse_reg(exec_pulse));
  dpc_host i_dpc_host (.clk(core_clk), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .mode(mode), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n));
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  // ****************************
  // compare and transfer tasks
  // ****************************
  task chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wchk;
    chk({4'h0, wiper0, wiper1}, {4'h0, ew[0], ew[1]});
  endtask
  task settle;
    ex = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge core_clk);
      ex = ex | (exec_pulse === 1'b1);
    end
  endtask
  task cmd(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d);
    i_dpc_host.xfer(24, {24'h0, op, a, d}, q);
    settle();
  endtask
  function automatic logic [9:0] step(input logic [3:0] op,
                                      input logic [9:0] v);
    case (op[3:1])
      3'b010:  return v >> 1;
      3'b011:  return (v == 10'h0) ? v : v - 10'h1;
      3'b110:  return (v == 10'h0) ? 10'h1 :
                      (v >= 10'h200) ? 10'h3ff : v << 1;
      default: return (v == 10'h3ff) ? v : v + 10'h1;
    endcase
  endfunction
  task complete_run;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************************
  // scenarios
  // ****************************
  task t_write;
    cmd(4'hb, 4'h0, 16'hfd55);
    ew[0] = 10'h155;
    chk({23'h0, ex}, 24'h1);
    cmd(4'hb, 4'hf, 16'h02aa);
    ew[1] = 10'h2aa;
    wchk();
  endtask
  task t_read;
    cmd(4'h3, 4'h5, 16'hbeef);
    cmd(4'h9, 4'h5, 16'h0);
    cmd(4'h0, 4'h3, 16'h1234);
    chk(q[23:0], 24'h95beef);
    cmd(4'h0, 4'h0, 16'h0);
    chk(q[23:0], 24'h031234);
    cmd(4'ha, 4'h1, 16'h0);
    cmd(4'h0, 4'h0, 16'h0);
    chk(q[23:0], {8'ha1, 6'h0, ew[1]});
    cmd(4'h3, 4'h0, 16'hfc12);
    em[0] = 16'hfc12;
    ew[0] = 10'h012;
    wchk();
  endtask
  task t_store;
    cmd(4'hb, 4'h1, 16'h0155);
    cmd(4'h2, 4'h1, 16'h0);
    em[1] = 16'h0155;
    cmd(4'hb, 4'h1, 16'h0);
    cmd(4'h1, 4'h1, 16'hffff);
    ew[1] = em[1][9:0];
    wchk();
    chk({23'h0, read_state}, 24'h1);
    cmd(4'h0, 4'hf, 16'hffff);
    wchk();
    chk({23'h0, read_state}, 24'h0);
    cmd(4'hb, 4'h0, 16'h0003);
    cmd(4'h8, 4'h0, 16'h0);
    ew[0] = em[0][9:0];
    wchk();
  endtask
  task t_steps;
    logic [7:0] seq [14];
    seq = '{8'h60, 8'he1, 8'hc0, 8'hd0, 8'h41, 8'h5e, 8'h70, 8'hf0,
            8'hc3, 8'hc1, 8'hc1, 8'he0, 8'h40, 8'h7f};
    cmd(4'hb, 4'h0, 16'h0);
    cmd(4'hb, 4'h1, 16'h03ff);
    ew[0] = 10'h0;
    ew[1] = 10'h3ff;
    for (int i = 0; i < 14; i++)
    begin
      cmd(seq[i][7:4], seq[i][3:0], 16'hffff);
      if (seq[i][4] || !seq[i][0])
        ew[0] = step(seq[i][7:4], ew[0]);
      if (seq[i][4] || seq[i][0])
        ew[1] = step(seq[i][7:4], ew[1]);
      wchk();
    end
  endtask
  task t_repeat;
    cmd(4'h6, 4'h1, 16'h0);
    i_dpc_host.pulse();
    settle();
    chk({23'h0, ex}, 24'h1);
    ew[1] = step(4'h6, step(4'h6, ew[1]));
    wchk();
  endtask
  task t_bad;
    i_dpc_host.xfer(23, {25'h0, 7'h58, 16'h0111}, q);
    settle();
    chk({23'h0, ex}, 24'h0);
    wchk();
    cmd(4'hb, 4'h0, 16'h02a5);
    ew[0] = 10'h2a5;
    wchk();
  endtask
  task t_chain;
    i_dpc_host.xfer(48, 48'hb10111_b00222, q);
    settle();
    ew[0] = 10'h222;
    chk(q[23:0], 24'hb10111);
    chk(q[47:24], 24'hb002a5);
    wchk();
  endtask
  task t_mode1;
    i_dpc_host.set_mode(1'b1);
    cmd(4'hb, 4'h1, 16'h03c3);
    ew[1] = 10'h3c3;
    wchk();
    cmd(4'ha, 4'h1, 16'h0);
    cmd(4'h0, 4'h0, 16'h0);
    chk(q[23:0], 24'ha103c3);
    i_dpc_host.set_mode(1'b0);
  endtask
  // watchdog
  initial
  begin
    #500000;
    fails++;
    complete_run();
  end
  // main sequence
  initial
  begin
    ew = '{10'h200, 10'h200};
    for (int i = 0; i < 16; i++)
      em[i] = 16'h0200;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge core_clk);
    wchk();
    chk({22'h0, read_state, miso_oe_n}, 24'h1);
    t_write();
    t_read();
    t_store();
    t_steps();
    t_repeat();
    t_bad();
    t_chain();
    t_mode1();
    complete_run();
  end
endmodule
